/* File: ecw_map.vh */
`ifndef ECW_MAP_VH
`define ECW_MAP_VH
// ==========================================
// Register addresses
`define ECW_ADDR_SYS_EN 7'h04
`define ECW_ADDR_GLOBAL 7'h60
`define ECW_ADDR_SYS_EV 7'h61
`define ECW_ADDR_TRX_EV 7'h63
`define ECW_ADDR_WAKE_EV 7'h64
// ==========================================
// Field positions
`define ECW_GLB_SYS 0
`define ECW_GLB_TRX 2
`define ECW_GLB_WAKE 3
`define ECW_SYS_SERIAL_FAIL 1
`define ECW_SYS_OVERTEMP 2
`define ECW_SYS_POWER_ON 4
`define ECW_TRX_BUS_WAKE 0
`define ECW_TRX_BUS_FAIL 1
`define ECW_TRX_SILENCE 4
`define ECW_TRX_FRAME_ERR 5
`define ECW_WK_FALL 0
`define ECW_WK_RISE 1
// ==========================================
// Writable masks and reset values
`define ECW_SYS_EN_MASK 8'h06
`define ECW_SYS_EV_MASK 8'h16
`define ECW_TRX_EV_MASK 8'h33
`define ECW_WAKE_EV_MASK 8'h03
`define ECW_SYS_EN_RST 8'h00
`define ECW_SYS_EV_RST 8'h10
`define ECW_ZERO8 8'h00
// ==========================================
// Mode codes and timing
`define ECW_CODE_SLEEP 3'h1
`define ECW_MODE_STANDBY 2'h0
`define ECW_MODE_SLEEP 2'h1
`define ECW_MODE_OTHER 2'h2
`define ECW_CLK_MHZ 200
`define ECW_EVENT_DELAY_NS 400000
`define ECW_NS_PER_US 1000
`endif

/* File: ecw_event_capture.v */
`include "ecw_map.vh"
module ecw_event_capture #(
  parameter EVENT_DELAY_NS = `ECW_EVENT_DELAY_NS,
  parameter EVENT_DELAY_CYC = EVENT_DELAY_NS / `ECW_NS_PER_US * `ECW_CLK_MHZ
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Register access
  input wire [6:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // Event sources, one-cycle pulses
  input wire overtemp_warning_evt,
  input wire serial_failure_evt,
  input wire partial_net_frame_error_evt,
  input wire bus_silence_evt,
  input wire bus_failure_evt,
  input wire bus_wake_evt,
  input wire wake_rise_evt,
  input wire wake_fall_evt,
  // Enables held elsewhere
  input wire bus_silence_capture_en,
  input wire bus_failure_capture_en,
  input wire bus_wake_capture_en,
  input wire wake_rise_capture_en,
  input wire wake_fall_capture_en,
  // Mode and supply
  input wire transceiver_offline,
  input wire mode_cmd_valid,
  input wire [2:0] mode_control_code,
  input wire uv_forced_sleep,
  // Outputs
  output reg rxd_out,
  output reg [1:0] op_mode,
  output reg [7:0] global_event_summary
);

  // ==========================================
  // Registers
  reg [7:0] system_capture_enable_q;
  reg [7:0] system_event_flags_q;
  reg [7:0] transceiver_event_flags_q;
  reg [7:0] wake_pin_event_flags_q;
  reg [31:0] delay_cnt_q;
  reg delay_run_q;

  function [7:0] w1c_next;
    input [7:0] cur;
    input [7:0] set;
    input [7:0] mask;
    input hit;
    input [7:0] wdata;
    begin
      // Set wins over a clear landing in the same cycle
      w1c_next = ((cur & ~(hit ? wdata : `ECW_ZERO8)) | set) & mask;
    end
  endfunction

  // ==========================================
  // Decode
  wire wr_sys_en = reg_wr && reg_addr == `ECW_ADDR_SYS_EN;
  wire wr_sys = reg_wr && reg_addr == `ECW_ADDR_SYS_EV;
  wire wr_trx = reg_wr && reg_addr == `ECW_ADDR_TRX_EV;
  wire wr_wake = reg_wr && reg_addr == `ECW_ADDR_WAKE_EV;

  // ==========================================
  // Event sets
  reg [7:0] sys_set;
  reg [7:0] trx_set;
  reg [7:0] wake_set;
  always @* begin
    sys_set = `ECW_ZERO8;
    trx_set = `ECW_ZERO8;
    wake_set = `ECW_ZERO8;
    sys_set[`ECW_SYS_OVERTEMP] = overtemp_warning_evt &
      system_capture_enable_q[`ECW_SYS_OVERTEMP];
    sys_set[`ECW_SYS_SERIAL_FAIL] = serial_failure_evt &
      system_capture_enable_q[`ECW_SYS_SERIAL_FAIL];
    trx_set[`ECW_TRX_FRAME_ERR] = partial_net_frame_error_evt;
    trx_set[`ECW_TRX_SILENCE] = bus_silence_evt &
      bus_silence_capture_en;
    trx_set[`ECW_TRX_BUS_FAIL] = bus_failure_evt &
      bus_failure_capture_en;
    trx_set[`ECW_TRX_BUS_WAKE] = bus_wake_evt & bus_wake_capture_en;
    wake_set[`ECW_WK_RISE] = wake_rise_evt & wake_rise_capture_en;
    wake_set[`ECW_WK_FALL] = wake_fall_evt & wake_fall_capture_en;
  end

  // A clear is any written 1 on a currently set flag
  wire clear_hit = (wr_sys && |(reg_wdata & system_event_flags_q)) ||
    (wr_trx && |(reg_wdata & transceiver_event_flags_q)) ||
    (wr_wake && |(reg_wdata & wake_pin_event_flags_q));

  wire [7:0] sys_d = w1c_next(system_event_flags_q, sys_set,
    `ECW_SYS_EV_MASK, wr_sys, reg_wdata);
  wire [7:0] trx_d = w1c_next(transceiver_event_flags_q, trx_set,
    `ECW_TRX_EV_MASK, wr_trx, reg_wdata);
  wire [7:0] wake_d = w1c_next(wake_pin_event_flags_q, wake_set,
    `ECW_WAKE_EV_MASK, wr_wake, reg_wdata);

  wire any_pending = |system_event_flags_q | |transceiver_event_flags_q |
    |wake_pin_event_flags_q;
  wire regular_wake_en = bus_wake_capture_en | wake_rise_capture_en |
    wake_fall_capture_en;

  // ==========================================
  // Flags and enables
  always @(posedge clk) begin
    if (!rst_b) begin
      system_capture_enable_q <= `ECW_SYS_EN_RST;
      system_event_flags_q <= `ECW_SYS_EV_RST;
      transceiver_event_flags_q <= `ECW_ZERO8;
      wake_pin_event_flags_q <= `ECW_ZERO8;
    end else if (uv_forced_sleep) begin
      // Undervoltage wipes all captured events, power-on flag too
      system_event_flags_q <= `ECW_ZERO8;
      transceiver_event_flags_q <= `ECW_ZERO8;
      wake_pin_event_flags_q <= `ECW_ZERO8;
    end else begin
      if (wr_sys_en) begin
        system_capture_enable_q <= reg_wdata & `ECW_SYS_EN_MASK;
      end
      system_event_flags_q <= sys_d;
      transceiver_event_flags_q <= trx_d;
      wake_pin_event_flags_q <= wake_d;
    end
  end

  // ==========================================
  // Delay timer
  always @(posedge clk) begin
    if (!rst_b) begin
      delay_run_q <= 1'b0;
      delay_cnt_q <= 32'h00000000;
    end else if (clear_hit) begin
      delay_run_q <= 1'b1;
      delay_cnt_q <= 32'h00000000;
    end else if (delay_run_q) begin
      if (delay_cnt_q >= EVENT_DELAY_CYC - 1) begin
        delay_run_q <= 1'b0;
      end
      delay_cnt_q <= delay_cnt_q + 32'h00000001;
    end
  end

  // ==========================================
  // Receive pin signalling
  always @(posedge clk) begin
    if (!rst_b) begin
      rxd_out <= 1'b1;
    end else if (clear_hit || delay_run_q) begin
      rxd_out <= 1'b1;
    end else begin
      // Only meaningful offline; online the pin is held high
      rxd_out <= !(transceiver_offline && any_pending);
    end
  end

  // ==========================================
  // Mode control
  always @(posedge clk) begin
    if (!rst_b) begin
      op_mode <= `ECW_MODE_STANDBY;
    end else if (uv_forced_sleep) begin
      op_mode <= `ECW_MODE_SLEEP;
    end else if (mode_cmd_valid) begin
      if (mode_control_code == `ECW_CODE_SLEEP) begin
        // Avoid a sleep with no way out
        op_mode <= (regular_wake_en && !any_pending) ?
          `ECW_MODE_SLEEP : `ECW_MODE_STANDBY;
      end else begin
        op_mode <= `ECW_MODE_OTHER;
      end
    end
  end

  // ==========================================
  // Summary and read port
  always @(posedge clk) begin
    if (!rst_b) begin
      global_event_summary <= `ECW_ZERO8;
      reg_rdata <= `ECW_ZERO8;
    end else begin
      global_event_summary <= `ECW_ZERO8;
      // Undervoltage wipes the flags, so the summary must follow
      global_event_summary[`ECW_GLB_WAKE] <= |wake_d && !uv_forced_sleep;
      global_event_summary[`ECW_GLB_TRX] <= |trx_d && !uv_forced_sleep;
      global_event_summary[`ECW_GLB_SYS] <= |sys_d && !uv_forced_sleep;
      if (reg_rd) begin
        // Reads have no side effect on the flags
        case (reg_addr)
          `ECW_ADDR_SYS_EN: reg_rdata <= system_capture_enable_q;
          `ECW_ADDR_GLOBAL: reg_rdata <= global_event_summary;
          `ECW_ADDR_SYS_EV: reg_rdata <= system_event_flags_q;
          `ECW_ADDR_TRX_EV: reg_rdata <= transceiver_event_flags_q;
          `ECW_ADDR_WAKE_EV: reg_rdata <= wake_pin_event_flags_q;
          default: reg_rdata <= `ECW_ZERO8;
        endcase
      end
    end
  end

endmodule

/* File: ecw_host.sv */
// ========
// Host side
module ecw_host (
  // Clock
  input wire logic clk,
  // Register access
  output logic [6:0] reg_addr = 7'h00,
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0,
  output logic [7:0] reg_wdata = 8'h00,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  // Flag-register callers pass only the bits seen set
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
endmodule

/* File: ecw_event_capture_assertions.sv */
// ========
// Port checks
module ecw_event_capture_assertions (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Stimulus
  input wire reg_wr,
  input wire [6:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire transceiver_offline,
  input wire mode_cmd_valid,
  input wire [2:0] mode_control_code,
  input wire uv_forced_sleep,
  input wire partial_net_frame_error_evt,
  input wire wake_rise_evt,
  input wire wake_rise_capture_en,
  // Results
  input wire rxd_out,
  input wire [1:0] op_mode,
  input wire [7:0] global_event_summary
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  a_summary_reserved: assert property (
    (global_event_summary & 8'hF2) == 8'h00) else $error("reserved set");
  a_online_rxd: assert property (
    !transceiver_offline |=> rxd_out) else $error("rxd low online");
  a_sleep_refused: assert property (
    mode_cmd_valid && mode_control_code == 3'h1 && !uv_forced_sleep &&
    global_event_summary != 8'h00 |=> op_mode == 2'h0)
    else $error("sleep with flags");
  a_other_code: assert property (
    mode_cmd_valid && mode_control_code != 3'h1 && !uv_forced_sleep
    |=> op_mode == 2'h2) else $error("bad mode");
  a_uv_sleep: assert property (
    uv_forced_sleep && !mode_cmd_valid
    |=> op_mode == 2'h1 && !global_event_summary[0])
    else $error("uv not sleep");
  a_frame_err: assert property (
    partial_net_frame_error_evt && !uv_forced_sleep
    |=> global_event_summary[2]) else $error("frame error lost");
  a_wake_rise: assert property (
    wake_rise_evt && wake_rise_capture_en && !uv_forced_sleep
    |=> global_event_summary[3]) else $error("rise lost");
  a_clear_release: assert property (
    reg_wr && reg_addr == 7'h64 && reg_wdata[1:0] == 2'h3 &&
    global_event_summary[3] |=> rxd_out [*6]) else $error("rxd not held");
endmodule
bind ecw_event_capture ecw_event_capture_assertions chk_u (.*);

/* File: event_capture_and_wake_flagging_tb.sv */
module event_capture_and_wake_flagging_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst_b, offline, mvalid, uv, rxd, wr, rd;
  logic [7:0] evt, rd8, wdata, rdata, gsum;
  logic [6:0] addr;
  logic [4:0] en;
  logic [2:0] mcode;
  logic [1:0] mode;
  int n_fail = 0;
  int checked = 0;
  // ========
  // Host and device
  ecw_host host_u (.clk(clk), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
    .reg_wdata(wdata), .reg_rdata(rdata));
  ecw_event_capture #(.EVENT_DELAY_CYC(8)) dut_u (.clk(clk), .rst_b(rst_b),
    .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata),
    .reg_rdata(rdata), .overtemp_warning_evt(evt[0]),
    .serial_failure_evt(evt[1]), .partial_net_frame_error_evt(evt[2]),
    .bus_silence_evt(evt[3]), .bus_failure_evt(evt[4]),
    .bus_wake_evt(evt[5]), .wake_rise_evt(evt[6]), .wake_fall_evt(evt[7]),
    .bus_silence_capture_en(en[0]), .bus_failure_capture_en(en[1]),
    .bus_wake_capture_en(en[2]), .wake_rise_capture_en(en[3]),
    .wake_fall_capture_en(en[4]), .transceiver_offline(offline),
    .mode_cmd_valid(mvalid), .mode_control_code(mcode),
    .uv_forced_sleep(uv), .rxd_out(rxd), .op_mode(mode),
    .global_event_summary(gsum));
  // ========
  // Tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
    host_u.rd(a, rd8);
    chk(rd8, exp);
  endtask
  task automatic pulse(input logic [7:0] v);
    @(negedge clk);
    evt = v;
    @(negedge clk);
    evt = 8'h00;
  endtask
  task automatic cmd(input logic [2:0] c);
    @(negedge clk);
    mcode = c;
    mvalid = 1'b1;
    @(negedge clk);
    mvalid = 1'b0;
  endtask
  task automatic final_report;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Tests need a little over a hundred cycles
  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    final_report;
  end
  // ========
  // Tests
  initial begin
    {rst_b, offline, mvalid, uv} = 4'h0;
    evt = 8'h00;
    en = 5'h00;
    mcode = 3'h0;
    repeat (8) @(negedge clk);
    rst_b = 1'b1;
    rchk(7'h61, 8'h10);
    rchk(7'h60, 8'h01);
    rchk(7'h10, 8'h00);
    host_u.wr(7'h04, 8'hFF);
    rchk(7'h04, 8'h06);
    offline = 1'b1;
    repeat (3) @(negedge clk);
    chk({7'h00, rxd}, 8'h00);
    host_u.wr(7'h61, 8'h00);
    rchk(7'h61, 8'h10);
    host_u.wr(7'h61, 8'h10);
    @(negedge clk);
    chk({7'h00, rxd}, 8'h01);
    pulse(8'h01);
    rchk(7'h61, 8'h04);
    chk({7'h00, rxd}, 8'h01);
    repeat (7) @(negedge clk);
    chk({7'h00, rxd}, 8'h00);
    host_u.wr(7'h61, 8'h04);
    repeat (12) @(negedge clk);
    chk({7'h00, rxd}, 8'h01);
    en = 5'h1F;
    for (int i = 0; i < 8; i++)
      pulse(8'h01 << i);
    rchk(7'h61, 8'h06);
    rchk(7'h63, 8'h33);
    rchk(7'h64, 8'h03);
    rchk(7'h60, 8'h0D);
    chk(gsum, 8'h0D);
    host_u.wr(7'h61, 8'h06);
    host_u.wr(7'h63, 8'h33);
    host_u.wr(7'h64, 8'h03);
    rchk(7'h60, 8'h00);
    en = 5'h00;
    host_u.wr(7'h04, 8'h00);
    pulse(8'hFF);
    rchk(7'h63, 8'h20);
    rchk(7'h61, 8'h00);
    cmd(3'h1);
    chk({6'h00, mode}, 8'h00);
    host_u.wr(7'h63, 8'h20);
    en = 5'h03;
    cmd(3'h1);
    chk({6'h00, mode}, 8'h00);
    en = 5'h04;
    cmd(3'h1);
    chk({6'h00, mode}, 8'h01);
    cmd(3'h2);
    chk({6'h00, mode}, 8'h02);
    pulse(8'h04);
    chk(gsum, 8'h04);
    uv = 1'b1;
    @(negedge clk);
    uv = 1'b0;
    chk({6'h00, mode}, 8'h01);
    rchk(7'h63, 8'h00);
    chk(gsum, 8'h00);
    final_report;
  end
endmodule
